// File: logic/lcs_defs.svh
`ifndef LCS_DEFS_SVH
`define LCS_DEFS_SVH

// serial frame layout
`define LCS_BYTE_BITS     8
`define LCS_BIT_CNT_LAST  3'h7
`define LCS_RW_BIT        0
`define LCS_SEL_BIT       1
`define LCS_CONT_BIT      7

// fixed upper part of the slave address byte, bits 7..2
`define LCS_ADDR_HI       6'h1c
`define LCS_RW_WRITE      1'b0

// timing: system clock period and least glitch-filter settle time
`define LCS_CLK_NS        50
`define LCS_FILT_NS       50
`define LCS_FILT_CYC      ((`LCS_FILT_NS + `LCS_CLK_NS - 1) / `LCS_CLK_NS)

// buffer entry: command flag, last-command flag, data byte
`define LCS_BUF_W         10
`define LCS_BUF_CMD_BIT   9
`define LCS_BUF_LAST_BIT  8

`endif

// File: logic/lcs_pkg.sv
package lcs_pkg;

  // receiver states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_HOLD,
    ST_ACK,
    ST_IGNORE
  } lcs_state_e;

endpackage

// File: logic/lcs_pipe_buf.sv
`timescale 1ns/100ps

module lcs_pipe_buf
  import lcs_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic         head_v_q;
  logic [W-1:0] head_q;
  logic         spare_v_q;
  logic [W-1:0] spare_q;
  logic         take_w;
  logic         give_w;

  // handshakes on both sides
  assign take_w    = in_valid & ~spare_v_q;
  assign give_w    = head_v_q & out_ready;
  assign in_ready  = ~spare_v_q;
  assign out_valid = head_v_q;
  assign out_data  = head_q;

  // head entry feeds the outputs, spare entry absorbs a stalled consumer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      head_v_q  <= 1'b0;
      head_q    <= '0;
      spare_v_q <= 1'b0;
      spare_q   <= '0;
    end else begin
      if (give_w || !head_v_q) begin
        if (spare_v_q) begin
          head_q    <= spare_q;
          head_v_q  <= 1'b1;
          spare_v_q <= take_w;
          if (take_w) begin
            spare_q <= in_data;
          end
        end else begin
          head_q   <= in_data;
          head_v_q <= take_w;
        end
      end else if (take_w) begin
        spare_q   <= in_data;
        spare_v_q <= 1'b1;
      end
    end
  end

endmodule

// File: logic/lcs_i2c_wr_slave.sv
`timescale 1ns/100ps
`include "lcs_defs.svh"

module lcs_i2c_wr_slave
  import lcs_pkg::*;
#(
  parameter int FILT_CYC = `LCS_FILT_CYC,
  parameter int BUF_W    = `LCS_BUF_W
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_select_pin,
  output logic            byte_valid,
  input  wire logic       byte_ready,
  output logic [7:0]      byte_data,
  output logic            byte_is_cmd,
  output logic            byte_last_cmd,
  output logic            bus_busy,
  output logic            dev_selected
);

  // filter counter width and its terminal count
  localparam int FCW = $clog2(FILT_CYC + 1);
  localparam logic [FCW-1:0] FILT_LAST = FCW'(FILT_CYC - 1);

  // index 0 carries the clock line, index 1 the data line
  logic [1:0]     meta_q;
  logic [1:0]     sync_q;
  logic [1:0]     line_q;
  logic [1:0]     prev_q;
  logic [FCW-1:0] fcnt_q [2];
  logic           sel_meta_q;
  logic           sel_sync_q;

  // receiver state and pin drive registers
  lcs_state_e     state_q;
  logic [2:0]     bit_cnt_q;
  logic [7:0]     shift_q;
  logic           got_byte_q;
  logic           cmd_mode_q;
  logic           sda_oe_q;
  logic           scl_oe_q;
  logic           busy_q;
  logic           selected_q;

  // bus condition and state decode
  logic           scl_rise_w;
  logic           scl_fall_w;
  logic           scl_hi_w;
  logic           start_w;
  logic           stop_w;
  logic           addr_ok_w;
  logic           byte_end_w;
  logic           push_w;
  logic           last_cmd_w;
  logic           st_addr_w;
  logic           st_data_w;
  logic           st_hold_w;
  logic           st_ack_w;
  logic           in_msg_w;

  // buffer side
  logic           buf_in_ready;
  logic [BUF_W-1:0] buf_in_data;
  logic [BUF_W-1:0] buf_out_data;

  // address byte check against the fixed pattern, the strap and the write direction
  function automatic logic addr_match(input logic [7:0] b, input logic sel);
    addr_match = (b[7:2] == `LCS_ADDR_HI)
               && (b[`LCS_SEL_BIT] == sel)
               && (b[`LCS_RW_BIT] == `LCS_RW_WRITE);
  endfunction

  // filter counter step: counts while the raw level differs from the filtered one
  function automatic logic [FCW-1:0] filt_step(input logic raw, input logic filt,
                                               input logic [FCW-1:0] cnt);
    if (raw == filt || cnt == FILT_LAST) begin
      filt_step = '0;
    end else begin
      filt_step = cnt + FCW'(1);
    end
  endfunction

  // two-stage synchronisers for the bus lines
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end else begin
      meta_q <= {sda_in, scl_in};
      sync_q <= meta_q;
    end
  end

  // the strap is a pin too, so it is synchronised before the address compare reads it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
    end else begin
      sel_meta_q <= addr_select_pin;
      sel_sync_q <= sel_meta_q;
    end
  end

  // glitch filter: a new level is taken only after it stays for FILT_CYC samples
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      line_q    <= 2'h3;
      prev_q    <= 2'h3;
      fcnt_q[0] <= '0;
      fcnt_q[1] <= '0;
    end else begin
      prev_q <= line_q;
      for (int i = 0; i < 2; i++) begin
        fcnt_q[i] <= filt_step(sync_q[i], line_q[i], fcnt_q[i]);
        if (sync_q[i] != line_q[i] && fcnt_q[i] == FILT_LAST) begin
          line_q[i] <= sync_q[i];
        end
      end
    end
  end

  // edge and bus condition decode on the filtered lines
  assign scl_rise_w = line_q[0] & ~prev_q[0];
  assign scl_fall_w = ~line_q[0] & prev_q[0];
  assign scl_hi_w   = line_q[0] & prev_q[0];
  assign start_w    = scl_hi_w & prev_q[1] & ~line_q[1];
  assign stop_w     = scl_hi_w & ~prev_q[1] & line_q[1];
  assign addr_ok_w  = addr_match(shift_q, sel_sync_q);
  assign byte_end_w = scl_fall_w & got_byte_q;

  // state decode shared by the push, the sequencing and the status flag
  assign st_addr_w = (state_q == ST_ADDR);
  assign st_data_w = (state_q == ST_DATA);
  assign st_hold_w = (state_q == ST_HOLD);
  assign st_ack_w  = (state_q == ST_ACK);
  assign in_msg_w  = st_data_w | st_hold_w | st_ack_w;

  // hand a received byte on, either at the eighth falling edge or when a stall ends;
  // in the stall state only the cycle before the data line is pulled pushes
  assign push_w = ~start_w & ~stop_w & buf_in_ready
                & ((st_data_w & byte_end_w) | (st_hold_w & ~sda_oe_q));
  assign last_cmd_w  = cmd_mode_q & ~shift_q[`LCS_CONT_BIT];
  assign buf_in_data = {cmd_mode_q, last_cmd_w, shift_q};

  // receiver sequencing: address, data bytes, acknowledge, ignore
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 3'h0;
      shift_q    <= 8'h00;
      got_byte_q <= 1'b0;
      sda_oe_q   <= 1'b0;
      scl_oe_q   <= 1'b0;
    end else if (stop_w) begin
      // a stop or a start aborts whatever byte is in flight
      state_q    <= ST_IDLE;
      got_byte_q <= 1'b0;
      sda_oe_q   <= 1'b0;
      scl_oe_q   <= 1'b0;
    end else if (start_w) begin
      state_q    <= ST_ADDR;
      bit_cnt_q  <= 3'h0;
      got_byte_q <= 1'b0;
      sda_oe_q   <= 1'b0;
      scl_oe_q   <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE: begin
          sda_oe_q <= 1'b0;
        end
        ST_ADDR, ST_DATA: begin
          // bits are taken on the rising clock, when the data line has settled
          if (scl_rise_w && !got_byte_q) begin
            shift_q   <= {shift_q[6:0], line_q[1]};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == `LCS_BIT_CNT_LAST) begin
              got_byte_q <= 1'b1;
            end
          end else if (byte_end_w) begin
            // eighth falling edge: acknowledge, ignore or stretch
            got_byte_q <= 1'b0;
            if (st_addr_w) begin
              // a foreign address leaves the data line released until start or stop
              if (addr_ok_w) begin
                sda_oe_q <= 1'b1;
                state_q  <= ST_ACK;
              end else begin
                state_q <= ST_IGNORE;
              end
            end else if (buf_in_ready) begin
              sda_oe_q <= 1'b1;
              state_q  <= ST_ACK;
            end else begin
              scl_oe_q <= 1'b1;
              state_q  <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // pull data low first and free the clock a cycle later, so the
          // acknowledge level is settled before the master sees the clock rise
          if (sda_oe_q) begin
            scl_oe_q <= 1'b0;
            state_q  <= ST_ACK;
          end else if (buf_in_ready) begin
            sda_oe_q <= 1'b1;
          end
        end
        ST_ACK: begin
          // the ninth falling edge ends the acknowledge; the next byte follows
          if (scl_fall_w) begin
            sda_oe_q  <= 1'b0;
            bit_cnt_q <= 3'h0;
            state_q   <= ST_DATA;
          end
        end
      endcase
    end
  end

  // continuation tracking: command bytes until one has bit 7 clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_mode_q <= 1'b0;
    end else if (start_w) begin
      cmd_mode_q <= 1'b1;
    end else if (push_w && last_cmd_w) begin
      cmd_mode_q <= 1'b0;
    end
  end

  // bus busy from start to stop, whoever is addressed
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else if (start_w) begin
      busy_q <= 1'b1;
    end else if (stop_w) begin
      busy_q <= 1'b0;
    end
  end

  // selected flag lags the state by one cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      selected_q <= 1'b0;
    end else begin
      selected_q <= in_msg_w;
    end
  end

  // two-entry buffer between the bus and the command consumer;
  // a full buffer makes the receiver stretch the clock instead of losing a byte
  lcs_pipe_buf #(
    .W (BUF_W)
  ) u_buf (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (push_w),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (byte_valid),
    .out_ready (byte_ready),
    .out_data  (buf_out_data)
  );

  // pins: both lines only ever pull low; the data line only for acknowledge
  assign sda_out       = 1'b0;
  assign sda_oe        = sda_oe_q;
  assign scl_out       = 1'b0;
  assign scl_oe        = scl_oe_q;

  // buffer head fields and status to the outputs
  assign byte_data     = buf_out_data[7:0];
  assign byte_is_cmd   = buf_out_data[`LCS_BUF_CMD_BIT];
  assign byte_last_cmd = buf_out_data[`LCS_BUF_LAST_BIT];
  assign bus_busy      = busy_q;
  assign dev_selected  = selected_q;

endmodule

// File: testbench/lcs_monitor.sv
`timescale 1ns/100ps
module lcs_monitor (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       scl_oe,
  input wire logic       byte_valid,
  input wire logic       byte_ready,
  input wire logic [7:0] byte_data,
  input wire logic       byte_is_cmd,
  input wire logic       byte_last_cmd,
  input wire logic       bus_busy,
  input wire logic       dev_selected
);
  logic [1:0] scl_q;
  // short copy of the clock pin, never later than the block's own view
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) scl_q <= 2'h3;
    else scl_q <= {scl_q[0], scl_in};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_oe_drives_low: assert property (sda_oe |-> !sda_out) else $error("data driven high");
  a_start_busy: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:6] bus_busy)
    else $error("start not seen");
  a_stop_idle: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:6] !bus_busy)
    else $error("stop not seen");
  a_stop_desel: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:7] !dev_selected)
    else $error("still selected after stop");
  a_idle_no_ack: assert property (!bus_busy |-> !sda_oe) else $error("ack outside transfer");
  a_ack_stable: assert property (scl_q == 2'h3 |-> $stable(sda_oe)) else $error("ack moved in high");
  a_stretch_full: assert property (scl_oe |-> byte_valid) else $error("stretch with room");
  a_valid_hold: assert property (byte_valid && !byte_ready |=> byte_valid &&
    $stable({byte_data, byte_is_cmd, byte_last_cmd})) else $error("byte lost");
  a_last_cmd: assert property (byte_valid && byte_last_cmd |-> byte_is_cmd && !byte_data[7])
    else $error("bad last flag");
endmodule

bind lcs_i2c_wr_slave lcs_monitor i_mon (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .scl_oe(scl_oe), .byte_valid(byte_valid), .byte_ready(byte_ready),
  .byte_data(byte_data), .byte_is_cmd(byte_is_cmd), .byte_last_cmd(byte_last_cmd), .bus_busy(bus_busy),
  .dev_selected(dev_selected));

// File: testbench/lcs_host_model.sv
`timescale 1ns/100ps
module lcs_host_model (
  input wire logic mclk,
  input wire logic scl,
  input wire logic sda,
  output logic     scl_lo,
  output logic     sda_lo,
  output logic     stuck
);
  // both lines released: bus idle
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    stuck  = 1'b0;
  end
  // a quarter of the 400 ns bus clock
  task automatic qtr();
    repeat (2) @(negedge mclk);
  endtask
  // one bit: data changes only while clock is low, waits out stretching
  task automatic bit_io(input logic v, output logic s);
    int n;
    sda_lo = !v;
    qtr();
    scl_lo = 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (scl !== 1'b1 && n < 3000);
    if (n >= 3000) stuck = 1'b1;
    @(negedge mclk);
    s = sda;
    qtr();
    scl_lo = 1'b1;
    qtr();
  endtask
  // data falls with clock high, from an idle bus or as a repeated start
  task automatic put_start();
    if (scl_lo) begin
      sda_lo = 1'b0;
      qtr();
      scl_lo = 1'b0;
      qtr();
    end
    sda_lo = 1'b1;
    qtr();
    scl_lo = 1'b1;
    qtr();
  endtask
  // data rises with clock high
  task automatic put_stop();
    sda_lo = 1'b1;
    qtr();
    scl_lo = 1'b0;
    qtr();
    sda_lo = 1'b0;
    qtr();
    qtr();
  endtask
  // eight bits first msb, then the acknowledge clock with data released
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import lcs_pkg::*;
  logic       mclk, sys_rst, sel, rdy, scl_oe, sda_oe, scl_out, sda_out;
  logic       bv, cmd, lastc, busy, dsel, scl_lo, sda_lo, stuck;
  logic [7:0] bd;
  logic [9:0] expq[$];
  int         seed, hold, miscompares, cmp_count;
  // open-drain lines with pull-ups
  wire logic  scl = !(scl_lo || scl_oe);
  wire logic  sda = !(sda_lo || sda_oe);

  lcs_i2c_wr_slave i_dut (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(sel), .byte_valid(bv), .byte_ready(rdy),
    .byte_data(bd), .byte_is_cmd(cmd), .byte_last_cmd(lastc), .bus_busy(busy), .dev_selected(dsel));
  lcs_host_model i_host (.mclk(mclk), .scl(scl), .sda(sda), .scl_lo(scl_lo), .sda_lo(sda_lo), .stuck(stuck));

  initial mclk = 1'b0;
  always #25 mclk = !mclk;

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // expected word {command, last command, data}; continuation ends at bit7 clear
  function automatic logic [9:0] exp_word(input logic [7:0] b, inout logic cont);
    exp_word = {cont, cont & !b[7], b};
    if (!b[7]) cont = 1'b0;
  endfunction

  // consumer: stalls while hold runs down, otherwise random
  always @(negedge mclk) begin
    if (hold > 0) hold <= hold - 1;
    rdy <= (hold == 0) ? 1'($random(seed)) : 1'b0;
  end

  // each handed-over byte against the next expected one
  always @(posedge mclk) begin
    if (!sys_rst && bv === 1'b1 && rdy === 1'b1) begin
      if (expq.size() == 0) chk({cmd, lastc, bd}, 10'h3ff);
      else chk({cmd, lastc, bd}, expq.pop_front());
    end
  end

  // kinds: 0 match, 1 wrong select bit, 2 read, 3 wrong fixed bits; last four stall
  // odd runs repeat the message after a repeated start; odd kind 3 sets address bit 2
  initial begin
    logic [7:0] ab, b;
    logic       ack, cont, hit;
    int         n, kind;
    seed = 99;
    sys_rst = 1'b1;
    sel = 1'b0;
    rdy = 1'b0;
    hold = 0;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (8) @(negedge mclk);
    for (int t = 0; t < 12; t++) begin
      kind = t % 8 / 2;
      sel = t[0];
      hit = (kind == 0);
      ab = {(kind == 3 && !t[0]) ? 5'h0f : 5'h0e, kind == 3 && t[0], sel ^ (kind == 1), kind == 2};
      if (t >= 8) hold = 400;
      repeat (10) @(negedge mclk);
      for (int r = 0; r <= int'(t[0]); r++) begin
        i_host.put_start();
        i_host.put_byte(ab, ack);
        chk(10'(ack), 10'(hit));
        chk(10'({scl_out, sda_out, dsel}), 10'(hit));
        cont = 1'b1;
        n = (t >= 8) ? 4 : 1 + ($random(seed) & 3);
        for (int k = 0; k < n; k++) begin
          b = 8'($random(seed));
          if (hit) expq.push_back(exp_word(b, cont));
          i_host.put_byte(b, ack);
          chk(10'(ack), 10'(hit));
        end
      end
      i_host.put_stop();
      n = 0;
      while (expq.size() != 0 && n < 2000) begin
        @(negedge mclk);
        n++;
      end
      repeat (4) @(negedge mclk);
      chk(10'(expq.size()), 10'h000);
      chk(10'({busy, dsel}), 10'h000);
      $display("test %0d done", t);
    end
    chk(10'(stuck), 10'h000);
    end_of_test();
  end
endmodule
